/* sim/plc_pll_ctrl_checker.sv */
/*
  Concurrent checks on the ports of the ratio and input-loss control block.
  Assumes one clock domain; bound to every plc_pll_ctrl instance below.
*/
`default_nettype none
module plc_pll_ctrl_checker #(
  parameter logic [23:0] LOSS_TIMEOUT_TICKS = 24'h0000c8,
  parameter logic [23:0] SKIP_LIMIT_TICKS = 24'h000032
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic timing_reference,
  input wire plc_pkg::plc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire plc_pkg::plc_ctl_t pll_ctl,
  input wire logic [47:0] effective_ratio,
  input wire logic [47:0] fracn_value
);
  localparam int LOSS_CLK = int'(LOSS_TIMEOUT_TICKS) * 8;
  logic ref_reg;
  logic skip_reg;
  logic unl_reg;
  logic [15:0] gap_reg;
  // ==========================================================================
  // helper: clk cycles since the last reference edge, shadow config bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_reg <= 1'b0;
      skip_reg <= 1'b0;
      unl_reg <= 1'b0;
      gap_reg <= 16'h0;
    end else begin
      ref_reg <= timing_reference;
      if (timing_reference && !ref_reg) begin
        gap_reg <= 16'h0;
      end else if (gap_reg != 16'hffff) begin
        gap_reg <= gap_reg + 16'h1;
      end
      if (reg_req.wr && reg_req.addr == 8'h0a) begin
        skip_reg <= reg_req.wdata[0];
        unl_reg <= reg_req.wdata[1];
      end
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_ratio_wr;
    reg_req.wr && (reg_req.addr inside {[8'h06:8'h09], 8'h0b});
  endsequence
  sequence s_hold_end;
    $fell(pll_ctl.fracn_hold) && gap_reg < 16'h0010;
  endsequence
  property p_wr_unlock;
    s_ratio_wr |-> ##2 pll_ctl.unlocked;
  endproperty
  property p_wr_wide;
    s_ratio_wr |-> ##2 pll_ctl.bw_wide;
  endproperty
  property p_bw_copy;
    reg_req.wr && reg_req.addr == 8'h0b |-> ##2 pll_ctl.bw_select == $past(reg_req.wdata[6:4], 2);
  endproperty
  property p_unl_low;
    pll_ctl.unlocked && !unl_reg && !$past(unl_reg) |-> !pll_ctl.out_enable;
  endproperty
  property p_hold_runs;
    pll_ctl.fracn_hold |-> pll_ctl.out_enable && !pll_ctl.unlocked;
  endproperty
  property p_no_early;
    $rose(pll_ctl.unlocked) && $past(pll_ctl.fracn_hold) && gap_reg > 16'h0020
      |-> gap_reg >= LOSS_CLK - 16;
  endproperty
  property p_no_late;
    pll_ctl.fracn_hold |-> gap_reg <= LOSS_CLK + 24;
  endproperty
  property p_skip_keep;
    s_hold_end ##0 skip_reg |-> !pll_ctl.unlocked && pll_ctl.out_enable && pll_ctl.bw_wide;
  endproperty
  property p_noskip_acq;
    s_hold_end ##0 !skip_reg |-> pll_ctl.unlocked && pll_ctl.bw_wide;
  endproperty
  property p_unmapped;
    reg_req.rd && reg_req.addr > 8'h0c |=> reg_rdata == 8'h00;
  endproperty
  a_wr_unlock: assert property (p_wr_unlock) else $error("no unlock after ratio write");
  a_wr_wide: assert property (p_wr_wide) else $error("no wide bandwidth on acquire");
  a_bw_copy: assert property (p_bw_copy) else $error("bandwidth code not applied");
  a_unl_low: assert property (p_unl_low) else $error("output runs while unlocked");
  a_hold_runs: assert property (p_hold_runs) else $error("holdover without output");
  a_no_early: assert property (p_no_early) else $error("loss timeout too early");
  a_no_late: assert property (p_no_late) else $error("loss timeout too late");
  a_skip_keep: assert property (p_skip_keep) else $error("skip return lost lock");
  a_noskip_acq: assert property (p_noskip_acq) else $error("return did not reacquire");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : plc_pll_ctrl_checker
bind plc_pll_ctrl plc_pll_ctrl_checker #(
  .LOSS_TIMEOUT_TICKS(LOSS_TIMEOUT_TICKS),
  .SKIP_LIMIT_TICKS(SKIP_LIMIT_TICKS)
) i_plc_pll_ctrl_checker (
  .clk(clk),
  .nrst(nrst),
  .timing_reference(timing_reference),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .pll_ctl(pll_ctl),
  .effective_ratio(effective_ratio),
  .fracn_value(fracn_value)
);
`default_nettype wire

/* sim/plc_pll_ctrl_tb.sv */
/*
  Self-checking bench: byte register calls, reference gaps and a step change of period.
  Assumes the design, the reference model and the checker are compiled.
*/
`default_nettype none
module plc_pll_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst;
  logic ref_run;
  logic [15:0] ref_half;
  logic timing_reference;
  plc_pkg::plc_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  plc_pkg::plc_ctl_t pll_ctl;
  logic [47:0] effective_ratio, fracn_value;
  logic [7:0] rdat;
  int failures;
  int check_count;
  int cyc;
  // ==========================================================================
  // clock, design and reference source
  always #5 clk = ~clk;
  plc_pll_ctrl #(.LOSS_TIMEOUT_TICKS(24'h0000c8), .SKIP_LIMIT_TICKS(24'h000032)) i_plc_pll_ctrl (
    .clk(clk), .nrst(nrst), .timing_reference(timing_reference), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .pll_ctl(pll_ctl), .effective_ratio(effective_ratio),
    .fracn_value(fracn_value));
  plc_ref_src i_plc_ref_src (.clk(clk), .run(ref_run), .half(ref_half),
    .ref_out(timing_reference));
  // ==========================================================================
  // tasks
  task automatic end_sim;
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clk);
    reg_req.rd = 1'b0;
    rdat = reg_rdata;
  endtask : rd
  task automatic wait_unl(input logic want, input int lim);
    int n;
    n = 0;
    while (pll_ctl.unlocked !== want && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_unl
  // 24.24 view of the user ratio times the modifier
  function automatic logic [47:0] exp_eff(input logic [31:0] u, input logic hi,
                                          input logic [2:0] m);
    logic [47:0] b;
    b = hi ? {16'h0, u} << 4 : {16'h0, u} << 12;
    return m[2] ? b >> ({1'b0, m[1:0]} + 3'h1) : b << m[1:0];
  endfunction : exp_eff
  // ==========================================================================
  // watchdog against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      end_sim();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    reg_req = '0;
    ref_run = 1'b0;
    ref_half = 16'h0028;
    failures = 0;
    check_count = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    chk("out_enable", 48'h0, pll_ctl.out_enable);
    for (int i = 6; i < 12; i++) begin
      rd(8'(i));
      chk("reset_reg", 48'h0, rdat);
    end
    wr(8'h0c, 8'hff);
    rd(8'h0c);
    chk("status_state", 48'h0, rdat[2:0]);
    rd(8'h3f);
    chk("unmapped", 48'h0, rdat);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h10);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h00);
    for (int f = 0; f < 2; f++) begin
      for (int m = 0; m < 8; m++) begin
        wr(8'h0a, {5'h0, f[0], 2'h0});
        wr(8'h0b, {5'h0, m[2:0]});
        repeat (4) @(negedge clk);
        chk("eff_ratio", exp_eff(32'h0010_0000, f[0], m[2:0]), effective_ratio);
      end
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'(6 + i));
      chk("ratio_byte", (i == 1) ? 48'h10 : 48'h0, rdat);
    end
    wr(8'h0b, 8'h50);
    chk("bw_wide", 48'h1, pll_ctl.bw_wide);
    ref_run = 1'b1;
    wait_unl(1'b0, 3000);
    chk("unlocked", 48'h0, pll_ctl.unlocked);
    chk("bw_wide", 48'h0, pll_ctl.bw_wide);
    chk("bw_select", 48'h5, pll_ctl.bw_select);
    chk("out_enable", 48'h1, pll_ctl.out_enable);
    repeat (100) @(negedge clk);
    chk("fracn_value", exp_eff(32'h0010_0000, 1'b1, 3'h0) / 48'd10, fracn_value);
    // short gap, skipping off
    ref_run = 1'b0;
    repeat (250) @(negedge clk);
    chk("fracn_hold", 48'h1, pll_ctl.fracn_hold);
    chk("unlocked", 48'h0, pll_ctl.unlocked);
    repeat (50) @(negedge clk);
    ref_run = 1'b1;
    wait_unl(1'b1, 100);
    chk("unlocked", 48'h1, pll_ctl.unlocked);
    wait_unl(1'b0, 3000);
    // short gap, skipping on: output never stops
    wr(8'h0a, 8'h05);
    ref_run = 1'b0;
    for (int n = 0; n < 500; n++) begin
      @(negedge clk);
      ref_run = (n >= 300);
      chk("unlocked", 48'h0, pll_ctl.unlocked);
      chk("out_enable", 48'h1, pll_ctl.out_enable);
    end
    repeat (1200) @(negedge clk);
    // long loss of reference
    ref_run = 1'b0;
    repeat (1400) @(negedge clk);
    chk("unlocked", 48'h0, pll_ctl.unlocked);
    chk("out_enable", 48'h1, pll_ctl.out_enable);
    repeat (400) @(negedge clk);
    chk("unlocked", 48'h1, pll_ctl.unlocked);
    chk("out_enable", 48'h0, pll_ctl.out_enable);
    ref_run = 1'b1;
    repeat (240) @(negedge clk);
    chk("unlocked", 48'h1, pll_ctl.unlocked);
    wait_unl(1'b0, 3000);
    chk("unlocked", 48'h0, pll_ctl.unlocked);
    // step change of period
    ref_half = 16'h0014;
    wait_unl(1'b1, 400);
    chk("unlocked", 48'h1, pll_ctl.unlocked);
    ref_half = 16'h0028;
    wait_unl(1'b0, 3000);
    // output kept on during unlock
    wr(8'h0a, 8'h07);
    wr(8'h06, 8'h00);
    repeat (2) @(negedge clk);
    chk("unlocked", 48'h1, pll_ctl.unlocked);
    chk("out_enable", 48'h1, pll_ctl.out_enable);
    end_sim();
  end
endmodule : plc_pll_ctrl_tb
`default_nettype wire

/* sim/plc_ref_src.sv */
/*
  Model of the frequency reference source: a square wave whose half period
  is counted in clk cycles; it stops low and stays low while run is low.
  Assumes the bench holds run and half steady between cycles.
*/
`default_nettype none
module plc_ref_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] half,
  output logic ref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // one whole period per pass, stopping cleanly at a low level
  initial ref_out = 1'b0;
  always begin
    @(negedge clk);
    if (run) begin
      ref_out = 1'b1;
      repeat (half) @(negedge clk);
      ref_out = 1'b0;
      repeat (half - 16'h1) @(negedge clk);
    end
  end
endmodule : plc_ref_src
`default_nettype wire

/* src/plc_edge_monitor.sv */
/*
  Synchronises the frequency reference pin, detects its rising edges and
  measures its period in internal timing clock ticks; flags period changes.
  Assumes tick is a one-cycle enable on clk.
*/
`default_nettype none
`include "plc_params.svh"
module plc_edge_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic pin,
  input wire logic rearm,
  output logic edge_seen,
  output logic period_chg,
  output logic [23:0] period
);
  typedef struct packed {
    logic s1, s2, s3;
    logic [23:0] cnt, last, period;
    logic edge_p, chg_p;
  } plc_mon_state_t;
  plc_mon_state_t r_reg, r_next;

  function automatic logic [23:0] absdiff(input logic [23:0] a, input logic [23:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction : absdiff

  // ========================================================================
  // sync, edge detect, period measure
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.edge_p = 1'b0;
    r_next.chg_p = 1'b0;
    if (tick && r_reg.cnt != 24'hff_ffff) begin
      r_next.cnt = r_reg.cnt + 24'h1;
    end
    if (rearm) begin
      r_next.last = 24'h0; // first period after a gap is not compared
    end
    if (r_reg.s2 && !r_reg.s3) begin
      r_next.edge_p = 1'b1;
      r_next.period = r_reg.cnt;
      r_next.last = r_reg.cnt;
      r_next.cnt = 24'h0;
      if (r_reg.last != 24'h0 &&
          absdiff(r_reg.cnt, r_reg.last) > (r_reg.last >> `PLC_CHANGE_SHIFT)) begin
        r_next.chg_p = 1'b1; // glitch or period step R5
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign edge_seen = r_reg.edge_p;
  assign period_chg = r_reg.chg_p;
  assign period = r_reg.period;
endmodule : plc_edge_monitor
`default_nettype wire

/* src/plc_params.svh */
/*
  Constants of the ratio and input-loss control block: register offsets, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from every file that needs them.
*/
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH
// ==========================================================================
// register map (byte registers)
`define PLC_ADDR_RATIO_FIRST 8'h06
`define PLC_ADDR_RATIO_LAST 8'h09
`define PLC_ADDR_CFG_A 8'h0a
`define PLC_ADDR_CFG_B 8'h0b
`define PLC_ADDR_STATUS 8'h0c
// ==========================================================================
// field positions and reset values
`define PLC_BIT_SKIP_EN 0
`define PLC_BIT_OUT_UNL 1
`define PLC_BIT_FMT_HIRES 2
`define PLC_MOD_LSB 0
`define PLC_BW_LSB 4
`define PLC_RST_RATIO 32'h0000_0000
`define PLC_RST_CFG_A 8'h00
`define PLC_RST_CFG_B 8'h00
// ==========================================================================
// timing
`define PLC_CLK_PERIOD_NS 10
`define PLC_INTERNAL_TIMING_CLOCK_DIV 8
`define PLC_SKIP_LIMIT_NS 20000000
`define PLC_LOSS_TIMEOUT_TICKS 24'h80_0000
`define PLC_ACQ_EDGES 4'h8
`define PLC_CHANGE_SHIFT 2
`endif

/* src/plc_pkg.sv */
/*
  Types of the ratio and input-loss control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package plc_pkg;
  // ========================================================================
  // loop state
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACQUIRE, ST_LOCKED, ST_HOLD, ST_UNLOCKED
  } plc_state_t;
  // configuration bits held in the register file
  typedef struct packed {
    logic skip_mode_enable;
    logic output_on_unlock;
    logic ratio_format_select;
    logic [2:0] modifier_select;
    logic [2:0] min_loop_bw_select;
  } plc_cfg_t;
  // control towards the synthesizer and output driver
  typedef struct packed {
    logic unlocked;
    logic out_enable;
    logic bw_wide;
    logic [2:0] bw_select;
    logic fracn_hold;
  } plc_ctl_t;
  // byte register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } plc_reg_req_t;
endpackage : plc_pkg
`default_nettype wire

/* src/plc_pll_ctrl.sv */
/*
  Top of the ratio and input-loss control block: byte register file, timing
  clock divider, loss-of-input timeout, skipping mode and lock state machine.
  Assumes a byte register port driven from clk and a frequency reference pin
  asynchronous to clk.
*/
// What this block does
// R1 - skipping on: loop stays locked across reference gaps up to 20 ms.
// R2 - system uses skipping only below 80 kHz with gaps under 20 ms.
// R3 - one configuration bit turns skipping on or off.
// R4 - after a clean stop, output continues 2^23 timing clock ticks.
// R5 - glitch or period change at removal unlocks at once, skipping the timeout.
// R6 - timeout expiry with input absent declares unlock; output follows unlock bit.
// R7 - input returning after timeout: stay unlocked through acquisition, then lock.
// R8 - skipping on, gap beyond limit but before timeout: no unlock flagged.
// R9 - skipping off, short gap: output runs, unlocked only while reacquiring.
// R10 - skipping on, short gap: output continuous through gap and reacquisition.
// R11 - three-bit field selects minimum loop bandwidth, 1 Hz to 128 Hz.
// R12 - wide bandwidth while acquiring, selected minimum once locked.
// R13 - user ratio held as unsigned 32-bit fixed point in ratio registers.
// R14 - format bit picks 12.20 or 20.12; reset gives 20.12.
// R15 - 12.20: 12 integer bits, 20 fraction bits.
// R16 - 20.12: 20 integer bits, 12 fraction bits.
// R17 - host prefers 12.20 whenever wanted ratio is below 4096.
// R18 - internal dividers compensated; user ratio is plain output/input ratio.
// R19 - modifier applied internally; stored user ratio stays unchanged.
// R20 - modifier codes give x1, x2, x4, x8, /2, /4, /8, /16.
// R21 - host leaves modifier at reset code for a factor of one.
// R22 - input frequency compared with output; ratio converted to timing clock basis.
// R23 - host avoids modifiers pushing effective ratio past 4096 in 12.20.
// R24 - unlocked: output held low unless output-on-unlock bit set.
// R25 - writing ratio, format or modifier settings unlocks the loop; the code unlocks on a format write only when the format bit changes.
// R26 - loss-of-input counter restarts on each reference edge, counts timing ticks.
`default_nettype none
`include "plc_params.svh"
module plc_pll_ctrl #(
  parameter logic [23:0] LOSS_TIMEOUT_TICKS = `PLC_LOSS_TIMEOUT_TICKS,
  parameter logic [23:0] SKIP_LIMIT_TICKS =
    24'(`PLC_SKIP_LIMIT_NS / (`PLC_CLK_PERIOD_NS * `PLC_INTERNAL_TIMING_CLOCK_DIV))
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic timing_reference,
  input wire plc_pkg::plc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output plc_pkg::plc_ctl_t pll_ctl,
  output logic [47:0] effective_ratio,
  output logic [47:0] fracn_value
);
  localparam logic [7:0] DIV_LAST = 8'(`PLC_INTERNAL_TIMING_CLOCK_DIV - 1);
  localparam logic [7:0] RST_A = `PLC_RST_CFG_A;
  localparam logic [7:0] RST_B = `PLC_RST_CFG_B;

  // ========================================================================
  // state
  typedef struct packed {
    logic [7:0] div;
    logic tick;
    logic [31:0] user_ratio;
    plc_pkg::plc_cfg_t cfg;
    logic ratio_valid;
    plc_pkg::plc_state_t state;
    logic [23:0] gap;
    logic [3:0] acq;
    logic reacq;
    logic rearm;
    logic calc_start;
    plc_pkg::plc_ctl_t ctl;
    logic [7:0] rdata;
  } plc_top_state_t;

  plc_top_state_t r_reg, r_next;
  logic edge_seen;
  logic period_chg;
  logic [23:0] period;
  logic fract_wr;
  logic absent;
  logic ratio_hit;
  logic [1:0] lane;

  // ========================================================================
  // helpers
  // ratio byte lane: offset 06 holds the top byte
  function automatic logic [1:0] ratio_lane(input logic [7:0] a);
    ratio_lane = 2'(`PLC_ADDR_RATIO_LAST - a);
  endfunction : ratio_lane

  function automatic logic is_ratio(input logic [7:0] a);
    is_ratio = (a >= `PLC_ADDR_RATIO_FIRST) && (a <= `PLC_ADDR_RATIO_LAST);
  endfunction : is_ratio

  function automatic logic [7:0] get_byte(input logic [31:0] v, input logic [1:0] l);
    get_byte = 8'(v >> {l, 3'h0});
  endfunction : get_byte

  function automatic logic [31:0] put_byte(input logic [31:0] v, input logic [1:0] l,
                                           input logic [7:0] b);
    logic [31:0] m;
    m = 32'h0000_00ff << {l, 3'h0};
    put_byte = (v & ~m) | ({24'h0, b} << {l, 3'h0});
  endfunction : put_byte

  function automatic logic is_unlocked(input plc_pkg::plc_state_t s);
    is_unlocked = (s == plc_pkg::ST_IDLE) || (s == plc_pkg::ST_ACQUIRE) ||
                  (s == plc_pkg::ST_UNLOCKED);
  endfunction : is_unlocked

  // ========================================================================
  // reference edge monitor and ratio arithmetic
  plc_edge_monitor u_mon (
    .clk(clk),
    .nrst(nrst),
    .tick(r_reg.tick),
    .pin(timing_reference),
    .rearm(r_reg.rearm),
    .edge_seen(edge_seen),
    .period_chg(period_chg),
    .period(period)
  );

  plc_ratio_calc u_calc (
    .clk(clk),
    .nrst(nrst),
    .start(r_reg.calc_start),
    .user_ratio(r_reg.user_ratio),
    .fmt_hires(r_reg.cfg.ratio_format_select),
    .mod_sel(r_reg.cfg.modifier_select),
    .period(period),
    .effective_ratio(effective_ratio),
    .fracn_value(fracn_value)
  );

  // ========================================================================
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.calc_start = 1'b0;
    r_next.rearm = 1'b0;
    fract_wr = 1'b0;
    ratio_hit = is_ratio(reg_req.addr);
    lane = ratio_lane(reg_req.addr);

    // internal timing clock enable
    r_next.tick = (r_reg.div == DIV_LAST);
    r_next.div = r_next.tick ? 8'h00 : r_reg.div + 8'h01;

    // register writes
    if (reg_req.wr) begin
      if (ratio_hit) begin
        r_next.user_ratio = put_byte(r_reg.user_ratio, lane, reg_req.wdata); // R13
        r_next.ratio_valid = 1'b1;
        fract_wr = 1'b1; // R25
      end else begin
        unique case (reg_req.addr)
          `PLC_ADDR_CFG_A: begin
            r_next.cfg.skip_mode_enable = reg_req.wdata[`PLC_BIT_SKIP_EN]; // R3
            r_next.cfg.output_on_unlock = reg_req.wdata[`PLC_BIT_OUT_UNL];
            r_next.cfg.ratio_format_select = reg_req.wdata[`PLC_BIT_FMT_HIRES]; // R14
            fract_wr = (reg_req.wdata[`PLC_BIT_FMT_HIRES] !=
                        r_reg.cfg.ratio_format_select); // R25
          end
          `PLC_ADDR_CFG_B: begin
            r_next.cfg.modifier_select = reg_req.wdata[`PLC_MOD_LSB +: 3]; // R20
            r_next.cfg.min_loop_bw_select = reg_req.wdata[`PLC_BW_LSB +: 3]; // R11
            fract_wr = 1'b1; // R25
          end
          default: begin
          end
        endcase
      end
    end

    // register reads, unmapped offsets read zero
    if (reg_req.rd) begin
      if (ratio_hit) begin
        r_next.rdata = get_byte(r_reg.user_ratio, lane);
      end else begin
        unique case (reg_req.addr)
          `PLC_ADDR_CFG_A: begin
            r_next.rdata = {5'h00, r_reg.cfg.ratio_format_select,
                            r_reg.cfg.output_on_unlock, r_reg.cfg.skip_mode_enable};
          end
          `PLC_ADDR_CFG_B: begin
            r_next.rdata = {1'b0, r_reg.cfg.min_loop_bw_select,
                            1'b0, r_reg.cfg.modifier_select};
          end
          `PLC_ADDR_STATUS: begin
            r_next.rdata = {3'h0, r_reg.reacq, r_reg.ctl.unlocked, r_reg.state};
          end
          default: begin
            r_next.rdata = 8'h00;
          end
        endcase
      end
    end

    // loss-of-input counter in timing clock ticks
    if (edge_seen) begin
      r_next.gap = 24'h0; // R26
    end else if (r_reg.tick && r_reg.gap != 24'hff_ffff) begin
      r_next.gap = r_reg.gap + 24'h1; // R26
    end
    absent = (r_reg.gap > {period[22:0], 1'b0}) && (period != 24'h0);

    // lock state machine
    unique case (r_reg.state)
      plc_pkg::ST_IDLE: begin
        // waits for a first ratio write
      end
      plc_pkg::ST_ACQUIRE: begin
        if (r_reg.gap >= LOSS_TIMEOUT_TICKS) begin
          r_next.state = plc_pkg::ST_UNLOCKED; // R6
        end else if (edge_seen && period_chg) begin
          r_next.acq = 4'h0;
          r_next.calc_start = 1'b1;
        end else if (edge_seen) begin
          r_next.calc_start = 1'b1; // R22
          r_next.acq = r_reg.acq + 4'h1;
          if (r_reg.acq == `PLC_ACQ_EDGES - 4'h1) begin
            r_next.state = plc_pkg::ST_LOCKED; // R12
          end
        end
      end
      plc_pkg::ST_LOCKED: begin
        if (edge_seen && period_chg) begin
          r_next.state = plc_pkg::ST_ACQUIRE; // R5
          r_next.acq = 4'h0;
          r_next.reacq = 1'b0;
          r_next.calc_start = 1'b1;
        end else if (edge_seen) begin
          r_next.calc_start = 1'b1; // R22
          if (r_reg.reacq) begin
            r_next.acq = r_reg.acq + 4'h1;
            r_next.reacq = (r_reg.acq != `PLC_ACQ_EDGES - 4'h1); // R12
          end
        end else if (absent) begin
          r_next.state = plc_pkg::ST_HOLD; // R4
        end
      end
      plc_pkg::ST_HOLD: begin
        if (r_reg.gap >= LOSS_TIMEOUT_TICKS) begin
          r_next.state = plc_pkg::ST_UNLOCKED; // R6 R4
        end else if (edge_seen) begin
          r_next.rearm = 1'b1;
          r_next.calc_start = 1'b1;
          r_next.acq = 4'h0;
          if (r_reg.cfg.skip_mode_enable) begin
            // short gap keeps lock (R1 R10); longer gap goes unflagged (R8)
            r_next.state = plc_pkg::ST_LOCKED; // R1 R10 R8
            r_next.reacq = 1'b1;
          end else begin
            r_next.state = plc_pkg::ST_ACQUIRE; // R9
          end
        end
      end
      plc_pkg::ST_UNLOCKED: begin
        if (edge_seen) begin
          r_next.state = plc_pkg::ST_ACQUIRE; // R7
          r_next.rearm = 1'b1;
          r_next.acq = 4'h0;
          r_next.calc_start = 1'b1;
        end
      end
    endcase

    // any change to the fractional value restarts acquisition
    if (fract_wr && r_next.ratio_valid) begin
      r_next.state = plc_pkg::ST_ACQUIRE; // R25
      r_next.acq = 4'h0;
      r_next.reacq = 1'b0;
      r_next.calc_start = 1'b1; // R19
    end

    // synthesizer and output control
    r_next.ctl.unlocked = is_unlocked(r_next.state); // R6
    if (r_next.state == plc_pkg::ST_IDLE) begin
      r_next.ctl.out_enable = 1'b0;
    end else if (r_next.ctl.unlocked) begin
      r_next.ctl.out_enable = r_next.cfg.output_on_unlock; // R24
    end else begin
      r_next.ctl.out_enable = 1'b1; // R4 R10
    end
    r_next.ctl.bw_wide = (r_next.state == plc_pkg::ST_ACQUIRE) || r_next.reacq; // R12
    r_next.ctl.bw_select = r_next.cfg.min_loop_bw_select; // R11
    r_next.ctl.fracn_hold = (r_next.state == plc_pkg::ST_HOLD); // R1
  end

  // ========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.user_ratio <= `PLC_RST_RATIO;
      r_reg.cfg <= {RST_A[`PLC_BIT_SKIP_EN], RST_A[`PLC_BIT_OUT_UNL], RST_A[`PLC_BIT_FMT_HIRES],
                    RST_B[`PLC_MOD_LSB +: 3], RST_B[`PLC_BW_LSB +: 3]};
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign pll_ctl = r_reg.ctl;
endmodule : plc_pll_ctrl
`default_nettype wire

/* src/plc_ratio_calc.sv */
/*
  Builds the effective ratio from the user ratio, format and modifier, then
  divides it by the input period to give the ratio against the timing clock.
  Assumes period and inputs are stable for the pulse on start.
*/
`default_nettype none
module plc_ratio_calc (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] user_ratio,
  input wire logic fmt_hires,
  input wire logic [2:0] mod_sel,
  input wire logic [23:0] period,
  output logic [47:0] effective_ratio,
  output logic [47:0] fracn_value
);
  typedef struct packed {
    logic [47:0] eff, fracn, dvd, quo;
    logic [23:0] rem, per;
    logic [5:0] cnt;
    logic busy;
  } plc_calc_state_t;
  plc_calc_state_t r_reg, r_next;
  logic [47:0] norm;
  logic [24:0] trial;
  logic [47:0] q_next;

  // modifier: x1..x8 or /2../16, stored ratio untouched
  function automatic logic [47:0] apply_mod(input logic [47:0] v, input logic [2:0] sel);
    apply_mod = sel[2] ? v >> ({1'b0, sel[1:0]} + 3'h1) : v << sel[1:0]; // R20
  endfunction : apply_mod

  // ========================================================================
  // effective ratio and serial divide, 24.24 fixed point
  always_comb begin
    r_next = r_reg;
    norm = fmt_hires ? {12'h0, user_ratio, 4'h0} // 12.20 R15
                     : {4'h0, user_ratio, 12'h0}; // 20.12 R16
    trial = {r_reg.rem, r_reg.dvd[47]};
    q_next = {r_reg.quo[46:0], 1'b0};
    if (start) begin
      r_next.eff = apply_mod(norm, mod_sel); // R19
      r_next.dvd = r_next.eff;
      r_next.quo = 48'h0;
      r_next.rem = 24'h0;
      r_next.per = period;
      r_next.cnt = 6'h2f;
      r_next.busy = (period != 24'h0);
    end else if (r_reg.busy) begin
      r_next.dvd = r_reg.dvd << 1;
      if (trial >= {1'b0, r_reg.per}) begin
        r_next.rem = 24'(trial - {1'b0, r_reg.per});
        q_next[0] = 1'b1;
      end else begin
        r_next.rem = trial[23:0];
      end
      r_next.quo = q_next;
      if (r_reg.cnt == 6'h0) begin
        r_next.busy = 1'b0;
        r_next.fracn = q_next; // ratio per timing clock tick R22 R18
      end else begin
        r_next.cnt = r_reg.cnt - 6'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign effective_ratio = r_reg.eff;
  assign fracn_value = r_reg.fracn;
endmodule : plc_ratio_calc
`default_nettype wire
